/* File: pkg/tcss_pkg.sv */
// Purpose: shared constants and types for the thermometer serial slave
// Assumes: system clock of CLK_MHZ, conversion counts derived from it
// Notes: conversion times double per extra resolution bit
package tcss_pkg;
    localparam int CLK_MHZ = 125;
    // bus address and command codes
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [7:0] CMD_START_CONV = 8'h51;
    localparam logic [7:0] CMD_STOP_CONV = 8'h22;
    localparam logic [7:0] CMD_CONFIG = 8'hac;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h54;
    localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
    // settings/status field positions
    localparam int DONE_BIT = 7;
    localparam int HIGH_FLAG_BIT = 6;
    localparam int LOW_FLAG_BIT = 5;
    localparam int NV_BUSY_BIT = 4;
    localparam int RES_HI_BIT = 3;
    localparam int RES_LO_BIT = 2;
    localparam int POL_BIT = 1;
    localparam int MODE_BIT = 0;
    // power-up values of the volatile fields
    localparam logic DONE_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;
    localparam logic NV_BUSY_RST = 1'b0;
    localparam logic [1:0] RES_RST = 2'b11;
    // longest conversion times in ns, per resolution 9..12 bits
    localparam longint CONV_9B_NS = 64'd93_750_000;
    localparam longint CONV_10B_NS = 64'd187_500_000;
    localparam longint CONV_11B_NS = 64'd375_000_000;
    localparam longint CONV_12B_NS = 64'd750_000_000;
    // longest time: round down
    localparam int CONV_9B_CYCLES = int'((CONV_9B_NS * CLK_MHZ) / 1000);
    localparam int CONV_CNT_W = 27;
    localparam int NV_WRITE_CYCLES = 1000;
    localparam int NV_CNT_W = 10;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TXACK = 3'b100,
        ST_IGNORE = 3'b101
    } tcss_state_t;

    typedef enum logic [1:0] {
        IDX_CTRL = 2'b00,
        IDX_CMD = 2'b01,
        IDX_DATA = 2'b10
    } tcss_byte_t;
endpackage

/* File: hdl/tcss_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs are asynchronous to the system clock
// Notes: output follows only when stages two and three agree
module tcss_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_val
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    wire agree = (ff2 == ff3);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ff1 <= RST_VAL;
            ff2 <= RST_VAL;
            ff3 <= RST_VAL;
            o_val <= RST_VAL;
        end else if (i_ce) begin
            ff1 <= i_pin;
            ff2 <= ff1;
            ff3 <= ff2;
            if (agree) begin
                o_val <= ff3;
            end
        end
    end
endmodule

/* File: hdl/tcss_conv_timer.sv */
// Purpose: conversion timer, length scaled by selected resolution
// Assumes: base count is the 9-bit time in system cycles
// Notes: a start while busy restarts the count
module tcss_conv_timer
    import tcss_pkg::*;
#(
    parameter int BASE_CYCLES = CONV_9B_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [1:0] i_res,
    output logic o_busy,
    output logic o_done
);
    logic [CONV_CNT_W-1:0] cnt;
    wire [CONV_CNT_W-1:0] base = CONV_CNT_W'(BASE_CYCLES);
    // each extra bit doubles the time
    wire [CONV_CNT_W-1:0] load = CONV_CNT_W'((base << i_res) - 1'b1);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_abort) begin
                o_busy <= 1'b0;
                cnt <= '0;
            end else if (i_start) begin
                o_busy <= 1'b1;
                cnt <= load;
            end else if (o_busy && cnt == '0) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
            end else if (o_busy) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

/* File: hdl/tcss_serial_slave.sv */
// Purpose: two-wire slave front end and settings/status register
// Assumes: temperature datapath presents trip results with O_CONV_DONE
// Notes: nonvolatile bits are mirrored to external storage
// How it works
// - settings register reached only through the config access command
// - polarity and mode are nonvolatile; other bits have fixed power-up
// - bit order: done, high, low, nv busy, res hi, res lo, pol, mode
// - done reads 0 from a start command until that conversion ends, then 1 (also through continuous restarts) and at power-up
// - high flag sets on upper trip, holds until written 0 or reset
// - low flag sets on lower trip, holds until written 0 or reset
// - nv busy reads 1 during a nonvolatile write, 0 at power-up
// - resolution bits, 11 at power-up, scale conversion time 9..12 bits
// - mode 1 runs one conversion per start, mode 0 runs continuously
// - clock is input only, data driven only as open drain
// - device is always slave; master makes clock, start and stop
// - start is data falling with clock high; repeated start allowed
// - stop is data rising with clock high and ends the transfer
// - receiver holds data low one clock as acknowledge
// - address is 1001 followed by the three address pins
// - control byte: address in bits 7..1, bit 0 set means read
// - config access command code is ac hex after write control byte
// - config write carries one data byte, acknowledged, then stop
// - config read returns one byte, then master nack and stop
// - soft reset 54 hex halts conversions, restores power-up state except nv busy, which runs to the end of a write
module tcss_serial_slave
    import tcss_pkg::*;
#(
    parameter int CONV_BASE_CYCLES = CONV_9B_CYCLES
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic I_CE,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE,
    input wire logic I_ADDR_PIN_2,
    input wire logic I_ADDR_PIN_1,
    input wire logic I_ADDR_PIN_0,
    input wire logic [1:0] I_NV_STORED,
    output logic [1:0] O_NV_STORE,
    output logic O_NV_WRITE,
    input wire logic I_TEMP_HIGH_TRIP,
    input wire logic I_TEMP_LOW_TRIP,
    output logic O_CONVERTING,
    output logic O_CONV_DONE,
    output logic [1:0] O_RESOLUTION,
    output logic O_TOUT
);
    import tcss_pkg::*;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic [2:0] addr_s;
    tcss_state_t state;
    tcss_byte_t byte_idx;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic rw;
    logic data_seen;
    logic sda_oe;
    logic conv_done;
    logic high_flag;
    logic low_flag;
    logic nv_busy;
    logic [NV_CNT_W-1:0] nv_cnt;
    logic [1:0] res;
    logic output_polarity;
    logic mode;
    logic nv_loaded;
    logic conv_cont;
    logic tout_state;
    logic tout;
    logic nv_write;
    logic t_busy;
    logic t_done;

    // clock is only ever sampled, data only ever pulled low
    assign O_SDA = 1'b0;
    assign O_SDA_OE = sda_oe;
    assign O_NV_STORE = {output_polarity, mode};
    assign O_NV_WRITE = nv_write;
    assign O_CONVERTING = t_busy;
    assign O_CONV_DONE = t_done;
    assign O_RESOLUTION = res;
    assign O_TOUT = tout;

    tcss_pin_sync #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_pin({I_SCL, I_SDA}),
        .o_val({scl_s, sda_s})
    );

    tcss_pin_sync #(.W(3), .RST_VAL(3'b000)) u_addr_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_pin({I_ADDR_PIN_2, I_ADDR_PIN_1, I_ADDR_PIN_0}),
        .o_val(addr_s)
    );

    // bus events, seen on the filtered copies
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_det = scl_s && scl_q && sda_q && !sda_s;
    wire stop_det = scl_s && scl_q && !sda_q && sda_s;

    wire byte_done = (state == ST_RX) && scl_fall
        && (bit_cnt == BITS_PER_BYTE);
    wire addr_match = (shreg[7:1] == {ADDR_FIXED, addr_s});
    wire is_cmd_byte = byte_done && (byte_idx == IDX_CMD);
    // only one data byte after the config command is taken
    wire wr_cfg = byte_done && (byte_idx == IDX_DATA)
        && (cmd == CMD_CONFIG) && !data_seen;
    wire do_ack = (byte_idx == IDX_CTRL) ? addr_match
        : (byte_idx == IDX_CMD) ? 1'b1 : wr_cfg;
    wire cmd_start = is_cmd_byte && (shreg == CMD_START_CONV);
    wire cmd_stop = is_cmd_byte && (shreg == CMD_STOP_CONV);
    wire soft_rst = is_cmd_byte && (shreg == CMD_SOFT_RESET);

    wire [7:0] cfg_value = {conv_done, high_flag, low_flag, nv_busy,
        res, output_polarity, mode};
    // other commands' data live outside this block
    wire [7:0] tx_value = (cmd == CMD_CONFIG) ? cfg_value
        : TX_IDLE_BYTE;
    wire nv_change = wr_cfg && !nv_busy
        && (shreg[POL_BIT:MODE_BIT] != {output_polarity, mode});
    wire auto_restart = t_done && conv_cont && !soft_rst;
    wire conv_start = cmd_start || auto_restart;

    // set beats clear on both trip flags
    wire next_high_flag = (t_done && I_TEMP_HIGH_TRIP) || (!soft_rst
        && (wr_cfg ? shreg[HIGH_FLAG_BIT] : high_flag));
    wire next_low_flag = (t_done && I_TEMP_LOW_TRIP) || (!soft_rst
        && (wr_cfg ? shreg[LOW_FLAG_BIT] : low_flag));

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (I_CE) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // slave protocol engine; it never drives the clock
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state <= ST_IDLE;
            byte_idx <= IDX_CTRL;
            bit_cnt <= '0;
            shreg <= '0;
            cmd <= '0;
            rw <= 1'b0;
            data_seen <= 1'b0;
            sda_oe <= 1'b0;
        end else if (I_CE) begin
            if (stop_det) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                state <= ST_RX;
                byte_idx <= IDX_CTRL;
                bit_cnt <= '0;
                data_seen <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                            shreg <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 1'b1;
                        end else if (byte_done) begin
                            if (byte_idx == IDX_CTRL) begin
                                rw <= shreg[0];
                            end
                            if (byte_idx == IDX_CMD) begin
                                cmd <= shreg;
                            end
                            if (wr_cfg) begin
                                data_seen <= 1'b1;
                            end
                            // hold low through the ninth clock
                            sda_oe <= do_ack;
                            state <= do_ack ? ST_ACK
                                : ST_IGNORE;
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                shreg <= tx_value;
                                sda_oe <= !tx_value[7];
                                bit_cnt <= 4'h1;
                                state <= ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                bit_cnt <= '0;
                                state <= ST_RX;
                                byte_idx <= (byte_idx == IDX_CTRL)
                                    ? IDX_CMD : IDX_DATA;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                state <= ST_TXACK;
                            end else begin
                                sda_oe <= !shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 1'b1;
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            // released line means last byte wanted
                            state <= sda_s ? ST_IGNORE
                                : ST_ACK;
                        end
                    end
                    ST_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // settings/status register and conversion control
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            conv_done <= DONE_RST;
            high_flag <= FLAG_RST;
            low_flag <= FLAG_RST;
            res <= RES_RST;
            conv_cont <= 1'b0;
            tout_state <= 1'b0;
            tout <= 1'b0;
        end else if (I_CE) begin
            high_flag <= next_high_flag;
            low_flag <= next_low_flag;
            if (soft_rst) begin
                conv_done <= DONE_RST;
                res <= RES_RST;
                conv_cont <= 1'b0;
                tout_state <= 1'b0;
            end else begin
                // done and busy bits ignore the written byte
                if (cmd_start) begin
                    conv_done <= 1'b0;
                    conv_cont <= !mode;
                end else if (t_done) begin
                    conv_done <= 1'b1;
                end
                if (cmd_stop) begin
                    conv_cont <= 1'b0;
                end
                if (wr_cfg) begin
                    res <= shreg[RES_HI_BIT:RES_LO_BIT];
                end
                if (t_done && I_TEMP_HIGH_TRIP) begin
                    tout_state <= 1'b1;
                end else if (t_done && I_TEMP_LOW_TRIP) begin
                    tout_state <= 1'b0;
                end
            end
            tout <= output_polarity ? tout_state : !tout_state;
        end
    end

    // stored bits reload after reset from the external copy
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            nv_loaded <= 1'b0;
            output_polarity <= 1'b0;
            mode <= 1'b0;
            nv_busy <= NV_BUSY_RST;
            nv_cnt <= '0;
            nv_write <= 1'b0;
        end else if (I_CE) begin
            nv_write <= nv_change;
            if (!nv_loaded) begin
                nv_loaded <= 1'b1;
                output_polarity <= I_NV_STORED[1];
                mode <= I_NV_STORED[0];
            end else if (nv_change) begin
                output_polarity <= shreg[POL_BIT];
                mode <= shreg[MODE_BIT];
                nv_busy <= 1'b1;
                nv_cnt <= NV_CNT_W'(NV_WRITE_CYCLES - 1);
            end else if (nv_busy && nv_cnt == '0) begin
                nv_busy <= 1'b0;
            end else if (nv_busy) begin
                nv_cnt <= nv_cnt - 1'b1;
            end
        end
    end

    tcss_conv_timer #(.BASE_CYCLES(CONV_BASE_CYCLES)) u_timer (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_start(conv_start),
        .i_abort(soft_rst),
        .i_res(res),
        .o_busy(t_busy),
        .o_done(t_done)
    );

    a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_s)
        else $error("data driven low while clock high");
    a_ignore_quiet: assert property (
        state == ST_IGNORE |=> !sda_oe)
        else $error("driving data in ignore state");
    a_ack_addr: assert property (
        I_CE && byte_done && byte_idx == IDX_CTRL && !addr_match
        |=> state == ST_IGNORE && !sda_oe)
        else $error("foreign address acknowledged");
    a_done_clear: assert property (
        I_CE && cmd_start |=> !conv_done && t_busy)
        else $error("start did not clear done");
    a_high_hold: assert property (
        I_CE && high_flag && !soft_rst
        && !(wr_cfg && !shreg[HIGH_FLAG_BIT]) |=> high_flag)
        else $error("high flag lost");
    a_low_set: assert property (
        I_CE && t_done && I_TEMP_LOW_TRIP |=> low_flag)
        else $error("low flag not set");
    a_nv_busy: assert property (
        nv_write |-> nv_busy ##1 (nv_busy || !I_CE) [*3])
        else $error("nv busy not shown during write");
    a_soft_reset: assert property (
        I_CE && soft_rst && !(t_done && I_TEMP_HIGH_TRIP)
        |=> res == RES_RST && conv_done && !t_busy && !high_flag)
        else $error("soft reset incomplete");
    a_tout_pol: assert property (
        I_CE ##1 I_CE
        |-> tout == ($past(output_polarity) ? $past(tout_state) : !$past(tout_state)))
        else $error("thermostat polarity wrong");
    a_one_shot: assert property (
        I_CE && t_done && !conv_cont && !cmd_start |=> !t_busy)
        else $error("one shot kept converting");
    c_cfg_write: cover property (@(posedge I_CLK_SYS) wr_cfg && I_CE);
    c_cfg_read: cover property (@(posedge I_CLK_SYS)
        state == ST_TX && cmd == CMD_CONFIG);
    c_soft_rst: cover property (@(posedge I_CLK_SYS) soft_rst && I_CE);
    c_foreign: cover property (@(posedge I_CLK_SYS) state == ST_IGNORE);
endmodule

/* File: dv/tcss_bus_master.sv */
// Purpose: behavioural two-wire bus master
// Assumes: pull-up on data, 20 system cycles a bit
// Notes: clock stands high between frames
module tcss_bus_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic q();
        repeat (5) @(posedge i_clk);
        #1;
    endtask
    // also serves as repeated start
    task automatic start();
        q();
        o_sda_oe = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b0;
        q();
    endtask
    task automatic bitx(input logic b, output logic r);
        q();
        o_sda_oe = ~b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule

/* File: dv/tb_tcss_serial_slave.sv */
// Purpose: self-checking bench for the serial slave
// Assumes: conversion base shortened to 50 cycles
// Notes: data line resolved as wired-and with pull-up
module tb_tcss_serial_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import tcss_pkg::*;
    localparam int BASE = 50;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic scl, m_oe, sda, oe, hi = 1'b0, lo = 1'b0, nvw, conv, done, tout;
    logic sdo;
    logic [2:0] addr = 3'h0;
    logic [1:0] nvs = 2'h0, nvo, res, pm, pm2;
    logic [7:0] lf = 8'h3b, v, rd, ctrl;
    logic a, nv_seen = 1'b0;
    int checks = 0, n_fail = 0, cnt = 0, conv_len = 0, n_done = 0;
    assign sda = ~m_oe & (oe ? sdo : 1'b1);
    assign ctrl = {ADDR_FIXED, addr, 1'b0};
    always #4 clk = ~clk;
    tcss_bus_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(m_oe));
    tcss_serial_slave #(.CONV_BASE_CYCLES(BASE)) DUT (.I_CLK_SYS(clk),
        .I_RSTN(rstn), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda), .O_SDA(sdo),
        .O_SDA_OE(oe), .I_ADDR_PIN_2(addr[2]), .I_ADDR_PIN_1(addr[1]),
        .I_ADDR_PIN_0(addr[0]), .I_NV_STORED(nvs), .O_NV_STORE(nvo),
        .O_NV_WRITE(nvw), .I_TEMP_HIGH_TRIP(hi), .I_TEMP_LOW_TRIP(lo),
        .O_CONVERTING(conv), .O_CONV_DONE(done), .O_RESOLUTION(res),
        .O_TOUT(tout));
    always @(posedge clk) begin
        if (conv === 1'b1) cnt++;
        if (done === 1'b1) begin
            conv_len = cnt;
            cnt = 0;
            n_done++;
        end
        if (nvw === 1'b1) nv_seen = 1'b1;
    end
    // f holds high flag, low flag and nv busy
    function automatic logic [7:0] exp_cfg(input logic [2:0] f,
        input logic [1:0] r, input logic [1:0] p);
        return {1'b1, f, r, p};
    endfunction
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_rng(input int g, input int l, input int h);
        checks++;
        if (g < l || g > h) begin
            n_fail++;
            $display("Error %0t: count %0d outside range", $time, g);
        end
    endtask
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic hdr(input logic [7:0] c);
        m.start();
        m.wr(ctrl, a);
        chk8({7'h0, a}, 8'h01);
        m.wr(c, a);
        chk8({7'h0, a}, 8'h01);
    endtask
    task automatic cmd(input logic [7:0] c);
        hdr(c);
        m.stop();
    endtask
    task automatic cfg_wr(input logic [7:0] d);
        hdr(CMD_CONFIG);
        m.wr(d, a);
        chk8({7'h0, a}, 8'h01);
        m.stop();
    endtask
    task automatic cfg_rd(output logic [7:0] d);
        hdr(CMD_CONFIG);
        m.start();
        m.wr(ctrl | 8'h01, a);
        chk8({7'h0, a}, 8'h01);
        m.rd(1'b1, d);
        m.stop();
    endtask
    // bounded wait on completed conversions
    task automatic wait_done(input int n);
        for (int i = 0; i < 4000 && n_done < n; i++) @(posedge clk);
        if (n_done < n) begin
            n_fail++;
            $display("Error %0t: conversion never ended", $time);
            results();
        end
    endtask
    initial begin
        v = rnd();
        addr = v[2:0];
        nvs = v[4:3];
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (10) @(posedge clk);
        cfg_rd(rd);
        chk8(rd, exp_cfg(3'b000, 2'b11, nvs));
        chk8({6'h0, res}, 8'h03);
        for (int k = 0; k < 2; k++) begin
            m.start();
            m.wr(k ? {4'h8, addr, 1'b0} : {ADDR_FIXED, ~addr, 1'b0}, a);
            chk8({7'h0, a}, 8'h00);
            m.stop();
        end
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            cfg_wr({1'b0, v[6:5], 1'b1, v[3:2], nvs});
            cfg_rd(rd);
            chk8(rd,
                exp_cfg({v[6:5], 1'b0}, v[3:2], nvs));
            chk8({6'h0, res}, {6'h0, v[3:2]});
        end
        pm = {~nvs[1], 1'b1};
        cfg_wr({6'h0, pm});
        cfg_rd(rd);
        chk8(rd, exp_cfg(3'b001, 2'b00, pm));
        chk8({5'h0, nv_seen, nvo}, {6'h1, pm});
        repeat (1100) @(posedge clk);
        cfg_rd(rd);
        chk8(rd, exp_cfg(3'b000, 2'b00, pm));
        hi = 1'b1;
        n_done = 0;
        cmd(CMD_START_CONV);
        wait_done(1);
        chk_rng(conv_len, BASE, BASE + 2);
        repeat (BASE * 2) @(posedge clk);
        #1;
        chk8({6'h0, conv, tout}, {7'h0, pm[1]});
        cfg_rd(rd);
        chk8(rd, exp_cfg(3'b100, 2'b00, pm));
        hi = 1'b0;
        lo = 1'b1;
        pm2 = {pm[1], 1'b0};
        cfg_wr({6'h0, pm2});
        n_done = 0;
        cmd(CMD_START_CONV);
        wait_done(3);
        #1;
        chk8({6'h0, conv, tout}, {6'h0, 1'b1, ~pm[1]});
        cmd(CMD_STOP_CONV);
        lo = 1'b0;
        repeat (200) @(posedge clk);
        cfg_rd(rd);
        // high flag was written 0 with the mode change and no trip since
        chk8(rd, exp_cfg(3'b010, 2'b00, pm2));
        chk8({7'h0, conv}, 8'h00);
        cmd(CMD_SOFT_RESET);
        cfg_rd(rd);
        chk8(rd, exp_cfg(3'b000, 2'b11, pm2));
        results();
    end
endmodule
